// ===== include/wfd_pkg.sv
// Constants, register map and carrier types of the wake frame detector
package wfd_pkg;
  localparam int NUM_FILTERS = 4;
  localparam int MASK_BITS = 31;
  localparam int SYNC_LEN = 6;
  localparam int ADDR_REPS = 16;
  localparam int ADDR_BYTES = 6;
  localparam int DA_SA_LEN = 12;
  localparam int POS_W = 16;
  localparam int CMD_FIELD = 8;
  localparam int START_FIELD = 8;
  localparam int CHK_FIELD = 16;
  localparam logic [7:0] SYNC_BYTE = 8'hFF;
  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [POS_W-1:0] POS_MAX = 16'hFFFF;

  // Register byte addresses
  localparam logic [7:0] REG_WCS = 8'h00;
  localparam logic [7:0] REG_MASK0 = 8'h04;
  localparam logic [7:0] REG_CMD = 8'h14;
  localparam logic [7:0] REG_START = 8'h18;
  localparam logic [7:0] REG_CHK01 = 8'h1C;
  localparam logic [7:0] REG_CHK23 = 8'h20;
  localparam logic [7:0] REG_STRIDE = 8'h04;

  // wake_control_status bit positions
  localparam int WCS_PAT_EN = 0;
  localparam int WCS_RWP_EN = 1;
  localparam int WCS_PAT_RCV = 2;
  localparam int WCS_RWP_RCV = 3;
  localparam int WCS_ROUTE_PME = 4;

  // Filter command bit positions
  localparam int CMD_EN_BIT = 0;
  localparam int CMD_MCAST_BIT = 3;

  typedef struct packed {
    logic valid;
    logic sof;
    logic eof;
    logic [7:0] data;
  } wfd_rx_beat_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } wfd_reg_req_t;

  typedef enum logic [1:0] {
    RWP_SEEK_SYNC = 2'b00,
    RWP_MATCH_ADDR = 2'b01,
    RWP_FOUND = 2'b10
  } wfd_rwp_state_t;
endpackage : wfd_pkg

// ===== hdl/wfd_crc_filter.sv
// One pattern filter: masked CRC-16 over a window of frame bytes
`timescale 1ns/1ps
module wfd_crc_filter (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire wfd_pkg::wfd_rx_beat_t beat,
  input wire logic [wfd_pkg::POS_W-1:0] cur_pos,
  input wire logic [wfd_pkg::MASK_BITS-1:0] byte_mask,
  input wire logic [7:0] pattern_start,
  input wire logic [15:0] expected_checksum,
  output logic crc_equal
);
  logic [15:0] crc_r;
  logic [wfd_pkg::POS_W-1:0] rel;
  logic in_window;

  // Fixed polynomial, MSB first, bytes in frame order
  function automatic logic [15:0] crc_step(input logic [15:0] c_in, input logic [7:0] d);
    logic [15:0] c;
    logic fb;
    c = c_in;
    for (int b = 7; b >= 0; b--)
    begin
      fb = c[15] ^ d[b];
      c = {c[14:0], 1'b0};
      if (fb)
      begin
        c = c ^ wfd_pkg::CRC_POLY;
      end
    end
    return c;
  endfunction : crc_step

  // Window starts at the programmed offset; offsets below the header are trusted to software
  assign rel = cur_pos - wfd_pkg::POS_W'(pattern_start);
  assign in_window = (cur_pos >= wfd_pkg::POS_W'(pattern_start)) && (rel < wfd_pkg::POS_W'(wfd_pkg::MASK_BITS))
    && byte_mask[rel[4:0]];

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      crc_r <= wfd_pkg::CRC_INIT;
    end
    else if (beat.valid)
    begin
      if (beat.sof)
      begin
        crc_r <= in_window ? crc_step(wfd_pkg::CRC_INIT, beat.data) : wfd_pkg::CRC_INIT;
      end
      else if (in_window)
      begin
        crc_r <= crc_step(crc_r, beat.data);
      end
    end
  end

  assign crc_equal = (crc_r == expected_checksum);

  chk_mask_window: assert property (@(posedge mclk) disable iff (sys_rst)
    (beat.valid && !beat.sof && !in_window) |=> $stable(crc_r))
    else $error("crc changed on a byte outside the masked window");
endmodule : wfd_crc_filter

// ===== hdl/wfd_rwp_detect.sv
// Remote wake packet scanner: sync stream then repeated station address
`timescale 1ns/1ps
module wfd_rwp_detect (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire wfd_pkg::wfd_rx_beat_t beat,
  input wire logic [wfd_pkg::POS_W-1:0] cur_pos,
  input wire logic [47:0] station_addr,
  output logic found
);
  wfd_pkg::wfd_rwp_state_t st_r;
  logic [2:0] sync_cnt_r;
  logic [2:0] byte_idx_r;
  logic [3:0] rep_cnt_r;
  logic scan;
  logic addr_eq;
  logic is_sync;
  logic extra_sync;

  assign scan = beat.valid && !beat.sof && (cur_pos >= wfd_pkg::POS_W'(wfd_pkg::DA_SA_LEN));
  assign addr_eq = (beat.data == station_addr[8*byte_idx_r +: 8]);
  assign is_sync = (beat.data == wfd_pkg::SYNC_BYTE);
  // A sync stream longer than six bytes must not count as a break
  assign extra_sync = is_sync && (byte_idx_r == 3'h0) && (rep_cnt_r == 4'h0);

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      st_r <= wfd_pkg::RWP_SEEK_SYNC;
      sync_cnt_r <= 3'h0;
      byte_idx_r <= 3'h0;
      rep_cnt_r <= 4'h0;
    end
    else if (beat.valid && beat.sof)
    begin
      st_r <= wfd_pkg::RWP_SEEK_SYNC;
      sync_cnt_r <= 3'h0;
      byte_idx_r <= 3'h0;
      rep_cnt_r <= 4'h0;
    end
    else if (scan)
    begin
      unique case (st_r)
        wfd_pkg::RWP_SEEK_SYNC:
        begin
          if (!is_sync)
          begin
            sync_cnt_r <= 3'h0;
          end
          else if (sync_cnt_r == 3'(wfd_pkg::SYNC_LEN - 1))
          begin
            st_r <= wfd_pkg::RWP_MATCH_ADDR;
            sync_cnt_r <= 3'h0;
            byte_idx_r <= 3'h0;
            rep_cnt_r <= 4'h0;
          end
          else
          begin
            sync_cnt_r <= sync_cnt_r + 3'h1;
          end
        end
        wfd_pkg::RWP_MATCH_ADDR:
        begin
          if (addr_eq)
          begin
            if (byte_idx_r == 3'(wfd_pkg::ADDR_BYTES - 1))
            begin
              byte_idx_r <= 3'h0;
              if (rep_cnt_r == 4'(wfd_pkg::ADDR_REPS - 1))
              begin
                st_r <= wfd_pkg::RWP_FOUND;
              end
              else
              begin
                rep_cnt_r <= rep_cnt_r + 4'h1;
              end
            end
            else
            begin
              byte_idx_r <= byte_idx_r + 3'h1;
            end
          end
          else if (!extra_sync)
          begin
            st_r <= wfd_pkg::RWP_SEEK_SYNC;
            sync_cnt_r <= is_sync ? 3'h1 : 3'h0;
            byte_idx_r <= 3'h0;
            rep_cnt_r <= 4'h0;
          end
        end
        wfd_pkg::RWP_FOUND:
        begin
          st_r <= wfd_pkg::RWP_FOUND;
        end
        default:
        begin
          st_r <= wfd_pkg::RWP_SEEK_SYNC;
        end
      endcase
    end
  end

  assign found = (st_r == wfd_pkg::RWP_FOUND);

  chk_sync_restart: assert property (@(posedge mclk) disable iff (sys_rst)
    (scan && st_r == wfd_pkg::RWP_MATCH_ADDR && !addr_eq && !extra_sync) |=> st_r == wfd_pkg::RWP_SEEK_SYNC)
    else $error("broken address run did not restart the sync search");
  chk_reps_complete: assert property (@(posedge mclk) disable iff (sys_rst)
    $rose(found) |-> ($past(rep_cnt_r) == 4'(wfd_pkg::ADDR_REPS - 1))
      && ($past(byte_idx_r) == 3'(wfd_pkg::ADDR_BYTES - 1)))
    else $error("remote wake found before sixteen full address copies");
  cov_rwp_found: cover property (@(posedge mclk) disable iff (sys_rst) $rose(found));
endmodule : wfd_rwp_detect

// ===== hdl/wfd_top.sv
// Wake frame detector: pattern filters, remote wake packet and control registers
//
// Local design decisions: the register addresses and strobed register access.
`timescale 1ns/1ps
module wfd_top (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire wfd_pkg::wfd_rx_beat_t rx_beat,
  input wire logic [47:0] station_addr,
  input wire logic light_sleep_state,
  input wire wfd_pkg::wfd_reg_req_t reg_req,
  output logic [31:0] reg_rdata,
  output logic normal_rx_enable,
  output logic host_wake_irq,
  output logic power_event_out
);
  localparam int NF = wfd_pkg::NUM_FILTERS;
  localparam logic [3:0] CMD_KEEP = (4'h1 << wfd_pkg::CMD_EN_BIT) | (4'h1 << wfd_pkg::CMD_MCAST_BIT);

  logic pattern_wake_enable_r;
  logic remote_wake_packet_enable_r;
  logic pattern_wake_received_r;
  logic remote_wake_packet_received_r;
  logic route_pme_r;
  logic pat_arm_r;
  logic rwp_arm_r;
  logic [wfd_pkg::MASK_BITS-1:0] mask_r [NF];
  logic [3:0] cmd_r [NF];
  logic [7:0] filter_pattern_start_r [NF];
  logic [15:0] filter_expected_checksum_r [NF];
  logic [wfd_pkg::POS_W-1:0] pos_r;
  logic [wfd_pkg::POS_W-1:0] cur_pos;
  logic dest_sta_r;
  logic dest_bc_r;
  logic group_r;
  logic eof_d_r;
  logic [NF-1:0] crc_ok;
  logic [NF-1:0] filt_hit;
  logic rwp_found;
  logic pat_hit;
  logic rwp_hit;
  logic wcs_wr;
  logic [31:0] rd_nxt;
  logic [31:0] reg_rdata_r;
  logic normal_rx_enable_r;
  logic host_wake_irq_r;
  logic power_event_out_r;

  assign wcs_wr = reg_req.wr && (reg_req.addr == wfd_pkg::REG_WCS);

  // Control and status
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pattern_wake_enable_r <= 1'b0;
      remote_wake_packet_enable_r <= 1'b0;
      route_pme_r <= 1'b0;
    end
    else if (wcs_wr)
    begin
      pattern_wake_enable_r <= reg_req.wdata[wfd_pkg::WCS_PAT_EN];
      remote_wake_packet_enable_r <= reg_req.wdata[wfd_pkg::WCS_RWP_EN];
      route_pme_r <= reg_req.wdata[wfd_pkg::WCS_ROUTE_PME];
    end
  end

  // Received flags clear by writing one; a hit in the same cycle wins
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pattern_wake_received_r <= 1'b0;
      remote_wake_packet_received_r <= 1'b0;
    end
    else
    begin
      if (pat_hit)
      begin
        pattern_wake_received_r <= 1'b1;
      end
      else if (wcs_wr && reg_req.wdata[wfd_pkg::WCS_PAT_RCV])
      begin
        pattern_wake_received_r <= 1'b0;
      end
      if (rwp_hit)
      begin
        remote_wake_packet_received_r <= 1'b1;
      end
      else if (wcs_wr && reg_req.wdata[wfd_pkg::WCS_RWP_RCV])
      begin
        remote_wake_packet_received_r <= 1'b0;
      end
    end
  end

  // Arming and receive gating; light sleep forces both detectors on
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pat_arm_r <= 1'b0;
      rwp_arm_r <= 1'b0;
      normal_rx_enable_r <= 1'b1;
    end
    else
    begin
      pat_arm_r <= pattern_wake_enable_r || light_sleep_state;
      rwp_arm_r <= remote_wake_packet_enable_r || light_sleep_state;
      normal_rx_enable_r <= !(pat_arm_r || rwp_arm_r);
    end
  end

  // Wake reporting
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      host_wake_irq_r <= 1'b0;
      power_event_out_r <= 1'b0;
    end
    else
    begin
      host_wake_irq_r <= !route_pme_r && (pattern_wake_received_r || remote_wake_packet_received_r);
      power_event_out_r <= route_pme_r && (pattern_wake_received_r || remote_wake_packet_received_r);
    end
  end

  // Frame byte position, restarting at zero with each frame
  assign cur_pos = rx_beat.sof ? '0 : pos_r;

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pos_r <= '0;
      eof_d_r <= 1'b0;
    end
    else
    begin
      eof_d_r <= rx_beat.valid && rx_beat.eof;
      if (rx_beat.valid && cur_pos != wfd_pkg::POS_MAX)
      begin
        pos_r <= cur_pos + wfd_pkg::POS_W'(1);
      end
    end
  end

  // Destination classification over the first six bytes
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      dest_sta_r <= 1'b0;
      dest_bc_r <= 1'b0;
      group_r <= 1'b0;
    end
    else if (rx_beat.valid && rx_beat.sof)
    begin
      dest_sta_r <= (rx_beat.data == station_addr[7:0]);
      dest_bc_r <= (rx_beat.data == wfd_pkg::SYNC_BYTE);
      group_r <= rx_beat.data[0];
    end
    else if (rx_beat.valid && cur_pos < wfd_pkg::POS_W'(wfd_pkg::ADDR_BYTES))
    begin
      dest_sta_r <= dest_sta_r && (rx_beat.data == station_addr[8*cur_pos[2:0] +: 8]);
      dest_bc_r <= dest_bc_r && (rx_beat.data == wfd_pkg::SYNC_BYTE);
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < NF; gi++)
    begin : g_filt
      localparam logic [7:0] MASK_ADDR = wfd_pkg::REG_MASK0 + 8'(gi) * wfd_pkg::REG_STRIDE;
      localparam logic [7:0] CHK_ADDR = (gi < 2) ? wfd_pkg::REG_CHK01 : wfd_pkg::REG_CHK23;

      always_ff @(posedge mclk or posedge sys_rst)
      begin
        if (sys_rst)
        begin
          mask_r[gi] <= '0;
          cmd_r[gi] <= 4'h0;
          filter_pattern_start_r[gi] <= 8'h00;
          filter_expected_checksum_r[gi] <= 16'h0000;
        end
        else if (reg_req.wr)
        begin
          if (reg_req.addr == MASK_ADDR)
          begin
            mask_r[gi] <= reg_req.wdata[wfd_pkg::MASK_BITS-1:0];
          end
          if (reg_req.addr == wfd_pkg::REG_CMD)
          begin
            cmd_r[gi] <= reg_req.wdata[gi*wfd_pkg::CMD_FIELD +: 4] & CMD_KEEP;
          end
          if (reg_req.addr == wfd_pkg::REG_START)
          begin
            filter_pattern_start_r[gi] <= reg_req.wdata[gi*wfd_pkg::START_FIELD +: 8];
          end
          if (reg_req.addr == CHK_ADDR)
          begin
            filter_expected_checksum_r[gi] <= reg_req.wdata[(gi%2)*wfd_pkg::CHK_FIELD +: 16];
          end
        end
      end

      wfd_crc_filter u_crc (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .beat(rx_beat),
        .cur_pos(cur_pos),
        .byte_mask(mask_r[gi]),
        .pattern_start(filter_pattern_start_r[gi]),
        .expected_checksum(filter_expected_checksum_r[gi]),
        .crc_equal(crc_ok[gi])
      );

      // Broadcast has the group bit, so it passes a multicast filter with no reject term
      assign filt_hit[gi] = cmd_r[gi][wfd_pkg::CMD_EN_BIT] && crc_ok[gi]
        && (cmd_r[gi][wfd_pkg::CMD_MCAST_BIT] ? group_r : dest_sta_r);
    end
  endgenerate

  wfd_rwp_detect u_rwp (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .beat(rx_beat),
    .cur_pos(cur_pos),
    .station_addr(station_addr),
    .found(rwp_found)
  );

  // Verdicts are taken the cycle after the last byte, when every CRC is final
  assign pat_hit = pat_arm_r && eof_d_r && (|filt_hit);
  assign rwp_hit = rwp_arm_r && eof_d_r && rwp_found && (dest_sta_r || dest_bc_r || group_r);

  // Register read, valid only in the cycle after the strobe
  always_comb
  begin
    rd_nxt = 32'h0000_0000;
    if (reg_req.addr == wfd_pkg::REG_WCS)
    begin
      rd_nxt[wfd_pkg::WCS_PAT_EN] = pattern_wake_enable_r;
      rd_nxt[wfd_pkg::WCS_RWP_EN] = remote_wake_packet_enable_r;
      rd_nxt[wfd_pkg::WCS_PAT_RCV] = pattern_wake_received_r;
      rd_nxt[wfd_pkg::WCS_RWP_RCV] = remote_wake_packet_received_r;
      rd_nxt[wfd_pkg::WCS_ROUTE_PME] = route_pme_r;
    end
    for (int i = 0; i < NF; i++)
    begin
      if (reg_req.addr == wfd_pkg::REG_MASK0 + 8'(i) * wfd_pkg::REG_STRIDE)
      begin
        rd_nxt = {1'b0, mask_r[i]};
      end
      if (reg_req.addr == wfd_pkg::REG_CMD)
      begin
        rd_nxt[i*wfd_pkg::CMD_FIELD +: 4] = cmd_r[i];
      end
      if (reg_req.addr == wfd_pkg::REG_START)
      begin
        rd_nxt[i*wfd_pkg::START_FIELD +: 8] = filter_pattern_start_r[i];
      end
      if (reg_req.addr == ((i < 2) ? wfd_pkg::REG_CHK01 : wfd_pkg::REG_CHK23))
      begin
        rd_nxt[(i%2)*wfd_pkg::CHK_FIELD +: 16] = filter_expected_checksum_r[i];
      end
    end
  end

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      reg_rdata_r <= 32'h0000_0000;
    end
    else
    begin
      reg_rdata_r <= reg_req.rd ? rd_nxt : 32'h0000_0000;
    end
  end

  assign reg_rdata = reg_rdata_r;
  assign normal_rx_enable = normal_rx_enable_r;
  assign host_wake_irq = host_wake_irq_r;
  assign power_event_out = power_event_out_r;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  chk_rx_gate_follows: assert property ((pattern_wake_enable_r || remote_wake_packet_enable_r)
    |-> ##2 !normal_rx_enable_r)
    else $error("normal reception still on two cycles after a wake enable");
  chk_rx_resume: assert property ((!pattern_wake_enable_r && !remote_wake_packet_enable_r
    && !light_sleep_state)[*2] |=> normal_rx_enable_r)
    else $error("normal reception not resumed after enables cleared");
  chk_sleep_arms_both: assert property (light_sleep_state |=> pat_arm_r && rwp_arm_r)
    else $error("light sleep did not arm both detectors");
  chk_pat_flag_set: assert property (pat_hit |=> pattern_wake_received_r)
    else $error("pattern match did not set its flag");
  chk_rwp_flag_set: assert property (rwp_hit |=> remote_wake_packet_received_r)
    else $error("remote wake did not set its flag");
  chk_pme_route: assert property ((route_pme_r && remote_wake_packet_received_r)
    |=> power_event_out_r && !host_wake_irq_r)
    else $error("remote wake not routed to the power event output");
  chk_irq_route: assert property ((!route_pme_r && remote_wake_packet_received_r)
    |=> host_wake_irq_r && !power_event_out_r)
    else $error("remote wake not routed to the host interrupt");
  chk_dest_gate: assert property ((eof_d_r && !wcs_wr && !(dest_sta_r || dest_bc_r || group_r))
    |=> $stable(remote_wake_packet_received_r))
    else $error("remote wake accepted for a foreign unicast frame");
  chk_pos_origin: assert property ((rx_beat.valid && rx_beat.sof) |=> pos_r == wfd_pkg::POS_W'(1))
    else $error("frame position did not restart at zero");

  cov_pattern_wake: cover property (pat_hit ##1 pattern_wake_received_r);
  cov_remote_wake: cover property (rwp_hit ##2 (host_wake_irq_r || power_event_out_r));
  cov_clear_race: cover property (pat_hit && wcs_wr && reg_req.wdata[wfd_pkg::WCS_PAT_RCV]);
endmodule : wfd_top

// ===== test/wfd_rx_feeder.sv
// Partner model: MAC receive datapath handing frame bytes to the detector
`timescale 1ns/1ps
module wfd_rx_feeder (
  input wire logic mclk,
  output wfd_pkg::wfd_rx_beat_t beat
);
  initial beat = '0;
  // Idle data is the inverse of the last byte, so a stale byte never looks fresh
  task automatic send(input logic [7:0] f[$], input int gap);
    for (int i = 0; i < f.size(); i++)
    begin
      @(posedge mclk);
      beat <= '{1'b1, i == 0, i == f.size() - 1, f[i]};
      if (gap != 0)
      begin
        @(posedge mclk);
        beat <= '{1'b0, 1'b0, 1'b0, ~f[i]};
      end
    end
    @(posedge mclk);
    beat <= '{1'b0, 1'b0, 1'b0, ~f[f.size() - 1]};
  endtask : send
endmodule : wfd_rx_feeder

// ===== test/wake_frame_detector_test.sv
// Self-checking bench for the wake frame detector
`timescale 1ns/1ps
module wake_frame_detector_test;
  typedef struct packed {
    logic [4:0] wcs;
    logic ls;
    logic [1:0] dst;
    logic [2:0] nff;
    logic [4:0] reps;
    logic brk;
    logic [1:0] exp;
  } wfd_row_t;
  localparam logic [47:0] st_addr = 48'h554433221100;
  logic mclk;
  logic sys_rst;
  wfd_pkg::wfd_rx_beat_t rx_beat;
  logic light_sleep_state;
  wfd_pkg::wfd_reg_req_t reg_req;
  logic [31:0] reg_rdata;
  logic normal_rx_enable;
  logic host_wake_irq;
  logic power_event_out;
  logic [7:0] frm[$];
  logic [31:0] d;
  int mismatches;
  int n_tests;
  // Fields: status write, light sleep, destination kind, sync length, copies, break, expected flags
  wfd_row_t rows[14] = '{
    '{5'h02, 1'h0, 2'h0, 3'h6, 5'h10, 1'h0, 2'h2},
    '{5'h12, 1'h0, 2'h1, 3'h6, 5'h10, 1'h0, 2'h2},
    '{5'h02, 1'h0, 2'h2, 3'h6, 5'h10, 1'h0, 2'h2},
    '{5'h02, 1'h0, 2'h3, 3'h6, 5'h10, 1'h0, 2'h0},
    '{5'h02, 1'h0, 2'h0, 3'h6, 5'h0F, 1'h0, 2'h0},
    '{5'h02, 1'h0, 2'h0, 3'h6, 5'h10, 1'h1, 2'h2},
    '{5'h02, 1'h0, 2'h0, 3'h5, 5'h10, 1'h0, 2'h0},
    '{5'h01, 1'h0, 2'h0, 3'h6, 5'h00, 1'h0, 2'h1},
    '{5'h11, 1'h0, 2'h1, 3'h6, 5'h00, 1'h0, 2'h1},
    '{5'h01, 1'h0, 2'h3, 3'h6, 5'h00, 1'h0, 2'h0},
    '{5'h01, 1'h0, 2'h0, 3'h5, 5'h00, 1'h0, 2'h0},
    '{5'h00, 1'h1, 2'h0, 3'h6, 5'h10, 1'h0, 2'h3},
    '{5'h00, 1'h0, 2'h0, 3'h6, 5'h10, 1'h0, 2'h0},
    '{5'h03, 1'h0, 2'h1, 3'h6, 5'h10, 1'h0, 2'h3}
  };

  wfd_top wfd_top_i (.mclk(mclk), .sys_rst(sys_rst), .rx_beat(rx_beat), .station_addr(st_addr),
    .light_sleep_state(light_sleep_state), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .normal_rx_enable(normal_rx_enable), .host_wake_irq(host_wake_irq), .power_event_out(power_event_out));
  wfd_rx_feeder wfd_rx_feeder_i (.mclk(mclk), .beat(rx_beat));

  task automatic wrap_up();
    if (mismatches == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    n_tests++;
    if (seen !== want)
    begin
      mismatches++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, want);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge mclk);
    reg_req <= '{a, v, 1'b1, 1'b0};
    @(posedge mclk);
    reg_req <= '{a, v, 1'b0, 1'b0};
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge mclk);
    reg_req <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge mclk);
    reg_req <= '{a, 32'h0, 1'b0, 1'b0};
    #1 d = reg_rdata;
  endtask : rd

  // Checksum over n bytes of all ones, worked out bit by bit
  function automatic logic [15:0] crc_ff(input int n);
    logic [15:0] c;
    c = wfd_pkg::CRC_INIT;
    for (int k = 0; k < 8 * n; k++)
      c = {c[14:0], 1'b0} ^ (~c[15] ? wfd_pkg::CRC_POLY : 16'h0000);
    return c;
  endfunction : crc_ff

  task automatic copies(input int n);
    for (int r = 0; r < 6 * n; r++)
      frm.push_back(st_addr[8 * (r % 6) +: 8]);
  endtask : copies

  task automatic mk(input wfd_row_t r);
    logic [47:0] da;
    da = r.dst == 2'h0 ? st_addr : r.dst == 2'h1 ? 48'hFFFFFFFFFFFF : r.dst == 2'h2 ? 48'h0100005E0001 : 48'h000000000002;
    frm = {};
    for (int i = 0; i < 6; i++)
      frm.push_back(da[8 * i +: 8]);
    for (int i = 0; i < 6; i++)
      frm.push_back(8'hA0 + 8'(i));
    if (r.brk)
    begin
      repeat (6) frm.push_back(8'hFF);
      copies(3);
      frm.push_back(8'h77);
    end
    repeat (r.nff) frm.push_back(8'hFF);
    copies(r.reps);
  endtask : mk

  task automatic run(input wfd_row_t r, input int gap);
    wr(wfd_pkg::REG_WCS, {27'h0, r.wcs});
    @(posedge mclk);
    light_sleep_state <= r.ls;
    repeat (3) @(posedge mclk);
    #1 chk(normal_rx_enable, !(r.ls || r.wcs[1:0] != 2'h0));
    mk(r);
    repeat (4) frm.push_back(8'h5A);
    wfd_rx_feeder_i.send(frm, gap);
    repeat (3) @(posedge mclk);
    rd(wfd_pkg::REG_WCS);
    chk(d[3:2], r.exp);
    chk(host_wake_irq, r.exp != 2'h0 && !r.wcs[4]);
    chk(power_event_out, r.exp != 2'h0 && r.wcs[4]);
    @(posedge mclk);
    light_sleep_state <= 1'b0;
    wr(wfd_pkg::REG_WCS, 32'h0000000C);
    repeat (3) @(posedge mclk);
    #1 chk({normal_rx_enable, host_wake_irq, power_event_out}, 3'h4);
  endtask : run

  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  initial
  begin
    #200000;
    mismatches++;
    wrap_up();
  end

  initial
  begin
    sys_rst = 1'b1;
    light_sleep_state = 1'b0;
    reg_req = '0;
    mismatches = 0;
    n_tests = 0;
    repeat (6) @(posedge mclk);
    sys_rst <= 1'b0;
    #1 chk({normal_rx_enable, host_wake_irq, power_event_out}, 3'h4);
    // Address 0x24 lies past the map and must read zero
    for (int i = 0; i < 10; i++)
    begin
      rd(8'(4 * i));
      chk(d, 32'h0);
    end
    wr(wfd_pkg::REG_MASK0, 32'hFFFFFFFF);
    rd(wfd_pkg::REG_MASK0);
    chk(d, 32'h7FFFFFFF);
    wr(wfd_pkg::REG_CMD, 32'hFFFFFFFF);
    rd(wfd_pkg::REG_CMD);
    chk(d, 32'h09090909);
    wr(8'h24, 32'hFFFFFFFF);
    rd(8'h24);
    chk(d, 32'h0);
    wr(wfd_pkg::REG_MASK0, 32'h0000003F);
    wr(wfd_pkg::REG_MASK0 + wfd_pkg::REG_STRIDE, 32'h0000001F);
    wr(wfd_pkg::REG_CMD, 32'h00000901);
    wr(wfd_pkg::REG_START, 32'h0C0C0D0C);
    wr(wfd_pkg::REG_CHK01, {crc_ff(5), crc_ff(6)});
    rd(wfd_pkg::REG_START);
    chk(d, 32'h0C0C0D0C);
    rd(wfd_pkg::REG_CHK01);
    chk(d, {crc_ff(5), crc_ff(6)});
    foreach (rows[i])
      run(rows[i], i % 3 == 2);
    // Half the copies end one frame, the other half open the next
    wr(wfd_pkg::REG_WCS, 32'h00000002);
    mk('{5'h02, 1'h0, 2'h0, 3'h6, 5'h08, 1'h0, 2'h0});
    wfd_rx_feeder_i.send(frm, 0);
    mk('{5'h02, 1'h0, 2'h0, 3'h0, 5'h08, 1'h0, 2'h0});
    wfd_rx_feeder_i.send(frm, 0);
    repeat (3) @(posedge mclk);
    rd(wfd_pkg::REG_WCS);
    chk(d[3:2], 2'h0);
    wr(wfd_pkg::REG_WCS, 32'h00000013);
    @(posedge mclk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    rd(wfd_pkg::REG_WCS);
    chk(d, 32'h0);
    wrap_up();
  end
endmodule : wake_frame_detector_test
